// ---- hw/hssc_top.sv ----
// sequencing core of a hot swap controller: comparator levels in,
// fet drive command and timer current source select out
// assumes comparators are analog and asynchronous; supply_lockout is
// also expected to hold nrst low externally
// Operation
// (R1) fet held off until lockout, initial, enable
// (R2) stay reset while supply lockout active
// (R3) initial timing cycle after reset ends
// (R4) start hot swap only when enabled
// (R5) enable counts only after 3 us filter
// (R6) enable low: fet down, timer pull-down
// (R7) rising filtered enable starts hot swap
// (R8) charge until limit, then regulate
// (R9) overcurrent times fault with pull-up
// (R10) current drops early: full on, pull-down
// (R11) timer high under overcurrent: fault, fet off
// (R12) latch-off retries only after enable toggles
// (R13) auto-retry retries forever with cooldown
// (R14) timer watched via high and low comparators
// (R15) four timer current sources selectable
// (R16) initial: 5 uA up, then 100 uA down
// (R17) fault timing uses 60 uA pull-up
// (R18) auto-retry cools down with 2 uA sink
// (R19) retry mode strap sampled at reset
// (R20) comparators pass two-stage synchroniser
`timescale 1ns/1ps
`default_nettype none
`include "hssc_map.svh"
module hssc_top
  import hssc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // comparator outputs, asynchronous
  input wire logic supply_lockout,
  input wire logic enable_cmp,
  input wire logic limit_cmp,
  input wire logic fault_timing_cmp,
  input wire logic timer_high_cmp,
  input wire logic timer_low_cmp,
  // strap: high selects auto-retry
  input wire logic auto_retry_strap,
  // drive commands and status flags
  output logic [2:0] fet_drive,
  output logic fet_pull_down,
  output logic [2:0] timer_source,
  output logic fault_flag,
  output logic initial_done
);
  typedef enum logic [2:0] {
    HSSC_ST_LOCK,
    HSSC_ST_INIT_UP,
    HSSC_ST_INIT_DN,
    HSSC_ST_IDLE,
    HSSC_ST_RUN,
    HSSC_ST_ON,
    HSSC_ST_FAULT,
    HSSC_ST_COOL
  } hssc_st_e_t;

  typedef struct packed {
    hssc_st_e_t st;
    logic strap_done;
    logic auto_retry;
    logic [`HSSC_CNT_W-1:0] filt_cnt;
    logic en_filt;
    logic en_prev;
    hssc_fet_t fet;
    logic pull_down;
    hssc_src_t src;
    logic fault;
    logic init_done;
  } hssc_state_t;

  localparam logic [`HSSC_CNT_W-1:0] FILT_CYC = `HSSC_CNT_W'(`HSSC_ON_FILT_CYC);

  logic [5:0] sync_out;
  logic lock_s, en_s, lim_s, oc_s, th_s, tl_s;
  logic supply_ok_s;
  hssc_state_t s_r;
  hssc_state_t s_nxt;

  hssc_sync #(.W(6)) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .din({~supply_lockout, enable_cmp, limit_cmp, fault_timing_cmp,
      timer_high_cmp, timer_low_cmp}),
    .dout(sync_out)
  );

  assign {supply_ok_s, en_s, lim_s, oc_s, th_s, tl_s} = sync_out; // [R20] [R14]
  // sync flops reset to 0, so carry supply-good: a fresh release reads as locked
  assign lock_s = ~supply_ok_s; // [R2]

  always_comb
  begin
    s_nxt = s_r;
    // strap caught once, first cycle after release
    if (!s_r.strap_done)
    begin
      s_nxt.strap_done = 1'b1;
      s_nxt.auto_retry = auto_retry_strap; // [R19]
    end
    // glitch filter: input must hold steady for the full window
    if (en_s == s_r.en_filt)
      s_nxt.filt_cnt = '0;
    else if (s_r.filt_cnt >= FILT_CYC - `HSSC_CNT_W'(1))
    begin
      s_nxt.filt_cnt = '0;
      s_nxt.en_filt = en_s; // [R5]
    end
    else
      s_nxt.filt_cnt = s_r.filt_cnt + `HSSC_CNT_W'(1);
    s_nxt.en_prev = s_r.en_filt;

    unique case (s_r.st)
      HSSC_ST_LOCK:
      begin
        if (!lock_s)
          s_nxt.st = HSSC_ST_INIT_UP; // [R3]
      end
      HSSC_ST_INIT_UP:
      begin
        if (tl_s)
          s_nxt.st = HSSC_ST_INIT_DN; // [R16]
      end
      HSSC_ST_INIT_DN:
      begin
        if (!tl_s)
        begin
          s_nxt.st = HSSC_ST_IDLE; // [R16]
          s_nxt.init_done = 1'b1;
        end
      end
      HSSC_ST_IDLE:
      begin
        // level start while fault is clear, edge start after a fault
        if (s_r.en_filt && (!s_r.fault || (!s_r.en_prev && s_r.en_filt)))
        begin
          s_nxt.st = HSSC_ST_RUN; // [R4] [R7] [R1]
          s_nxt.fault = 1'b0;
        end
      end
      HSSC_ST_RUN:
      begin
        if (!s_r.en_filt)
          s_nxt.st = HSSC_ST_IDLE; // [R6]
        else if (oc_s && th_s)
        begin
          s_nxt.fault = 1'b1; // [R11]
          s_nxt.st = s_r.auto_retry ? HSSC_ST_COOL : HSSC_ST_FAULT;
        end
        else if (!oc_s && !lim_s && s_r.src == HSSC_SRC_UP60)
          s_nxt.st = HSSC_ST_ON; // [R10]
      end
      HSSC_ST_ON:
      begin
        if (!s_r.en_filt)
          s_nxt.st = HSSC_ST_IDLE; // [R6]
        else if (oc_s)
          s_nxt.st = HSSC_ST_RUN; // [R9]
      end
      HSSC_ST_FAULT:
      begin
        // latch-off: wait for enable to drop before re-arming
        if (!s_r.en_filt)
          s_nxt.st = HSSC_ST_IDLE; // [R12]
      end
      HSSC_ST_COOL:
      begin
        if (!s_r.en_filt)
          s_nxt.st = HSSC_ST_IDLE;
        else if (!tl_s && !th_s)
        begin
          s_nxt.st = HSSC_ST_RUN; // [R13] [R18]
          s_nxt.fault = 1'b0;
        end
      end
    endcase
    if (lock_s)
    begin
      s_nxt.st = HSSC_ST_LOCK; // [R2]
      s_nxt.init_done = 1'b0;
      s_nxt.fault = 1'b0;
    end

    // outputs registered from next state
    s_nxt.fet = HSSC_FET_OFF;
    s_nxt.pull_down = 1'b1;
    s_nxt.src = HSSC_SRC_DN100;
    unique case (s_nxt.st)
      HSSC_ST_INIT_UP: s_nxt.src = HSSC_SRC_UP5; // [R16] [R15]
      HSSC_ST_RUN:
      begin
        s_nxt.pull_down = 1'b0;
        s_nxt.fet = lim_s ? HSSC_FET_REGULATE : HSSC_FET_CHARGE; // [R8]
        s_nxt.src = oc_s ? HSSC_SRC_UP60 : HSSC_SRC_DN100; // [R17] [R9]
      end
      HSSC_ST_ON:
      begin
        s_nxt.pull_down = 1'b0;
        s_nxt.fet = HSSC_FET_FULL; // [R10]
      end
      HSSC_ST_COOL: s_nxt.src = HSSC_SRC_DN2; // [R18]
      HSSC_ST_LOCK, HSSC_ST_INIT_DN, HSSC_ST_IDLE, HSSC_ST_FAULT:
        s_nxt.src = HSSC_SRC_DN100; // [R6]
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      s_r <= '{st: HSSC_ST_LOCK, fet: HSSC_FET_OFF, pull_down: 1'b1,
        src: HSSC_SRC_DN100, default: '0};
    else
      s_r <= s_nxt;
  end

  assign fet_drive = s_r.fet;
  assign fet_pull_down = s_r.pull_down;
  assign timer_source = s_r.src;
  assign fault_flag = s_r.fault;
  assign initial_done = s_r.init_done;

  chk_fet_held_off: assert property (@(posedge clk_sys) disable iff (!nrst) // [R1]
    !s_r.init_done |-> s_r.pull_down && s_r.fet == HSSC_FET_OFF)
    else $error("fet driven before initial cycle done");
  chk_lockout_reset: assert property (@(posedge clk_sys) disable iff (!nrst) // [R2]
    lock_s |=> s_r.st == HSSC_ST_LOCK && !s_r.init_done)
    else $error("not held in lockout");
  chk_enable_low_off: assert property (@(posedge clk_sys) disable iff (!nrst) // [R6]
    !s_r.en_filt && s_r.init_done |=> s_r.pull_down && s_r.src != HSSC_SRC_UP60)
    else $error("fet not pulled down with enable low");
  chk_filter_len: assert property (@(posedge clk_sys) disable iff (!nrst) // [R5]
    $rose(s_r.en_filt) |-> $past(en_s, 2) && $past(s_r.filt_cnt) == FILT_CYC - 1)
    else $error("enable filter too short");
  chk_fault_src: assert property (@(posedge clk_sys) disable iff (!nrst) // [R17]
    s_r.st == HSSC_ST_RUN && oc_s && !th_s && s_r.en_filt && !lock_s
    |=> s_r.src == HSSC_SRC_UP60)
    else $error("fault timing source wrong");
  chk_fault_abort: assert property (@(posedge clk_sys) disable iff (!nrst) // [R11]
    s_r.st == HSSC_ST_RUN && oc_s && th_s && s_r.en_filt && !lock_s
    |=> s_r.fault && s_r.pull_down)
    else $error("fault not aborted");
  chk_latch_hold: assert property (@(posedge clk_sys) disable iff (!nrst) // [R12]
    s_r.st == HSSC_ST_FAULT && s_r.en_filt && !lock_s |=> s_r.st == HSSC_ST_FAULT)
    else $error("latch-off left without enable toggle");
  chk_cool_src: assert property (@(posedge clk_sys) disable iff (!nrst) // [R18]
    s_r.st == HSSC_ST_COOL |-> s_r.src == HSSC_SRC_DN2 && s_r.auto_retry)
    else $error("cooldown source wrong");
  chk_init_up: assert property (@(posedge clk_sys) disable iff (!nrst) // [R16]
    s_r.st == HSSC_ST_INIT_UP |-> s_r.src == HSSC_SRC_UP5)
    else $error("initial pull-up wrong");
  cov_full_on: cover property (@(posedge clk_sys) s_r.fet == HSSC_FET_FULL);
  cov_latch: cover property (@(posedge clk_sys) s_r.st == HSSC_ST_FAULT);
  cov_retry: cover property (@(posedge clk_sys)
    s_r.st == HSSC_ST_COOL ##1 s_r.st == HSSC_ST_RUN);
  cov_regulate: cover property (@(posedge clk_sys) s_r.fet == HSSC_FET_REGULATE);
endmodule // hssc_top
`default_nettype wire

// ---- hw/hssc_map.svh ----
// constants for the hot swap sequence control block
// assumes a 50 MHz clk_sys
`ifndef HSSC_MAP_SVH
`define HSSC_MAP_SVH
`define HSSC_CLK_MHZ 50
`define HSSC_ON_FILT_US 3
`define HSSC_ON_FILT_CYC (`HSSC_ON_FILT_US * `HSSC_CLK_MHZ)
`define HSSC_CNT_W 8
`define HSSC_TIMER_HIGH_MV 1300
`define HSSC_TIMER_LOW_MV 200
`define HSSC_LIMIT_MV 100
`define HSSC_RETRY_DUTY_PERMILLE 38
`endif

// ---- hw/hssc_pkg.sv ----
// types for the hot swap sequence control block
// assumes hssc_map.svh is on the include path
package hssc_pkg;
  typedef enum logic [2:0] {
    HSSC_SRC_NONE,
    HSSC_SRC_UP5,
    HSSC_SRC_UP60,
    HSSC_SRC_DN2,
    HSSC_SRC_DN100
  } hssc_src_t;

  typedef enum logic [2:0] {
    HSSC_FET_OFF,
    HSSC_FET_CHARGE,
    HSSC_FET_REGULATE,
    HSSC_FET_FULL
  } hssc_fet_t;
endpackage

// ---- hw/hssc_sync.sv ----
// two-stage synchroniser for a bundle of comparator levels
// assumes levels change slowly against clk_sys
`timescale 1ns/1ps
`default_nettype none
module hssc_sync
  import hssc_pkg::*;
#(
  parameter int W = 6
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } hssc_sync_st_t;

  hssc_sync_st_t st_r;
  hssc_sync_st_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.meta = din; // [R20]
    st_nxt.sync = st_r.meta; // [R20]
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign dout = st_r.sync;
endmodule // hssc_sync
`default_nettype wire

// ---- bench/hssc_plant.sv ----
// model of the pass fet, shunt and timer capacitor around the block
// assumes one timer step per clk_sys: one unit per microamp, 10000 units per volt
`timescale 1ns/1ps
`default_nettype none
module hssc_plant
  import hssc_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // commands from the block
  input wire logic [2:0] fet_drive,
  input wire logic [2:0] timer_source,
  // load condition set by the bench
  input wire logic heavy_load,
  // comparator levels back to the block
  output logic limit_cmp,
  output logic fault_timing_cmp,
  output logic timer_high_cmp,
  output logic timer_low_cmp
);
  int cap_v = 0;
  always @(posedge clk_sys)
  begin
    int nxt;
    case (timer_source)
      HSSC_SRC_UP5: nxt = cap_v + 5;
      HSSC_SRC_UP60: nxt = cap_v + 60;
      HSSC_SRC_DN2: nxt = cap_v - 2;
      HSSC_SRC_DN100: nxt = cap_v - 100;
      default: nxt = cap_v;
    endcase
    // capacitor cannot go below ground
    cap_v <= (nxt < 0) ? 0 : nxt;
  end
  // no current flows while the gate is held off
  assign limit_cmp = heavy_load && (fet_drive != HSSC_FET_OFF);
  assign fault_timing_cmp = limit_cmp;
  assign timer_high_cmp = cap_v > 13000;
  assign timer_low_cmp = cap_v > 2000;
endmodule // hssc_plant
`default_nettype wire

// ---- bench/test_hssc_top.sv ----
// self-checking bench for the hot swap sequence control block
// assumes hssc_plant stands in for fet, shunt and timer capacitor
`timescale 1ns/1ps
`default_nettype none
`include "hssc_map.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); end end
`define WAITC(c, n) begin for (wn = 0; wn < (n) && !(c); wn++) @(negedge clk_sys); \
  if (!(c)) begin err_total++; close_out(); end end
module test_hssc_top
  import hssc_pkg::*;
;
  logic clk_sys = 0, nrst = 0, supply_lockout = 1, enable_cmp = 0;
  logic auto_retry_strap = 0, heavy_load = 0;
  logic limit_cmp, fault_timing_cmp, timer_high_cmp, timer_low_cmp;
  logic [2:0] fet_drive, timer_source;
  logic fet_pull_down, fault_flag, initial_done;
  int err_total = 0, check_count = 0, wn, gl;
  always #10 clk_sys = ~clk_sys;
  hssc_top dut_u (.clk_sys(clk_sys), .nrst(nrst), .supply_lockout(supply_lockout),
    .enable_cmp(enable_cmp), .limit_cmp(limit_cmp), .fault_timing_cmp(fault_timing_cmp),
    .timer_high_cmp(timer_high_cmp), .timer_low_cmp(timer_low_cmp),
    .auto_retry_strap(auto_retry_strap), .fet_drive(fet_drive),
    .fet_pull_down(fet_pull_down), .timer_source(timer_source),
    .fault_flag(fault_flag), .initial_done(initial_done));
  hssc_plant plant_u (.clk_sys(clk_sys), .fet_drive(fet_drive), .timer_source(timer_source),
    .heavy_load(heavy_load), .limit_cmp(limit_cmp), .fault_timing_cmp(fault_timing_cmp),
    .timer_high_cmp(timer_high_cmp), .timer_low_cmp(timer_low_cmp));
  // pulse stands gl+1 cycles; this is one cycle short of the filter
  function automatic int max_glitch();
    return `HSSC_ON_FILT_CYC - 2;
  endfunction
  task automatic close_out();
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic put(input logic lo, input logic en, input logic hv);
    @(posedge clk_sys);
    supply_lockout <= lo;
    enable_cmp <= en;
    heavy_load <= hv;
  endtask
  task automatic boot(input logic strap, input logic en);
    @(posedge clk_sys);
    nrst <= 1'b0;
    supply_lockout <= 1'b1;
    auto_retry_strap <= strap;
    enable_cmp <= en;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    // first two edges after release must not leave lockout
    repeat (2) @(negedge clk_sys);
    `CHK(timer_source, HSSC_SRC_DN100)
    repeat (18) @(negedge clk_sys);
    `CHK(timer_source, HSSC_SRC_DN100)
    `CHK(initial_done, 1'b0)
    put(1'b0, en, heavy_load);
    `WAITC(timer_source === HSSC_SRC_UP5, 20)
    `CHK(fet_pull_down, 1'b1)
    `WAITC(timer_source === HSSC_SRC_DN100, 600)
    `WAITC(initial_done === 1'b1, 600)
    `CHK(fet_drive, HSSC_FET_OFF)
  endtask
  initial
  begin
    void'($urandom(32'h8E05));
    boot(1'b0, 1'b0);
    repeat (300) @(negedge clk_sys);
    `CHK(fet_drive, HSSC_FET_OFF)
    `CHK(fet_pull_down, 1'b1)
    // pulses shorter than the filter never start the fet
    repeat (4)
    begin
      // first pass is the longest pulse, the rest random
      gl = (gl == 0) ? max_glitch() : $urandom_range(max_glitch(), 5);
      put(1'b0, 1'b1, 1'b1);
      repeat (gl) @(posedge clk_sys);
      put(1'b0, 1'b0, 1'b1);
      repeat (200) @(negedge clk_sys);
      `CHK(fet_drive, HSSC_FET_OFF)
    end
    put(1'b0, 1'b1, 1'b1);
    repeat (`HSSC_ON_FILT_CYC - 5) @(negedge clk_sys);
    `CHK(fet_drive, HSSC_FET_OFF)
    `WAITC(fet_drive === HSSC_FET_CHARGE, 20)
    `CHK(fet_pull_down, 1'b0)
    `WAITC(timer_source === HSSC_SRC_UP60, 10)
    `WAITC(fet_drive === HSSC_FET_REGULATE, 10)
    repeat ($urandom_range(100, 20)) @(posedge clk_sys);
    put(1'b0, 1'b1, 1'b0);
    `WAITC(fet_drive === HSSC_FET_FULL, 10)
    `CHK(timer_source, HSSC_SRC_DN100)
    put(1'b0, 1'b1, 1'b1);
    `WAITC(fault_flag === 1'b1, 400)
    `CHK(fet_drive, HSSC_FET_OFF)
    `CHK(fet_pull_down, 1'b1)
    repeat (400) @(negedge clk_sys);
    `CHK(fet_drive, HSSC_FET_OFF)
    put(1'b0, 1'b0, 1'b1);
    // low must outlast the filter, or the toggle is swallowed
    repeat (`HSSC_ON_FILT_CYC + 20) @(posedge clk_sys);
    `CHK(fet_drive, HSSC_FET_OFF)
    put(1'b0, 1'b1, 1'b1);
    `WAITC(fet_drive === HSSC_FET_CHARGE, 200)
    `CHK(fault_flag, 1'b0)
    put(1'b1, 1'b1, 1'b1);
    `WAITC(initial_done === 1'b0, 8)
    `CHK(fet_drive, HSSC_FET_OFF)
    boot(1'b1, 1'b1);
    @(posedge clk_sys);
    auto_retry_strap <= 1'b0;
    `WAITC(fault_flag === 1'b1, 600)
    `WAITC(timer_source === HSSC_SRC_DN2, 10)
    `CHK(fet_drive, HSSC_FET_OFF)
    `WAITC(fet_drive === HSSC_FET_CHARGE, 8000)
    `CHK(fault_flag, 1'b0)
    put(1'b0, 1'b0, 1'b0);
    `WAITC(fet_drive === HSSC_FET_OFF, 200)
    `CHK(fet_pull_down, 1'b1)
    close_out();
  end
endmodule // test_hssc_top
`default_nettype wire
